// [hdl/cms_consts.vh]
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH

// register indices; byte address is four times the index
`define CMS_IDX_STRETCH    8'h8e
`define CMS_IDX_DP0        8'h80
`define CMS_IDX_DP1        8'h81
`define CMS_IDX_CMD        8'h82
`define CMS_IDX_WDATA      8'h83
`define CMS_IDX_STATUS     8'h84
`define CMS_IDX_PORTCFG    8'h85
`define CMS_IDX_GPIO_OUT   8'h86
`define CMS_IDX_GPIO_OE    8'h87
`define CMS_IDX_GPIO_IN    8'h88
`define CMS_IDX_TIMER      8'h89
`define CMS_IDX_ICYCLES    8'h8a

// clock_and_stretch_control fields
`define CMS_CK_MD_LSB      0
`define CMS_CK_MD_MSB      2
`define CMS_CK_TFAST_BIT   3
`define CMS_CK_RESET       8'h01

// command fields
`define CMS_CMD_START_BIT  0
`define CMS_CMD_WRITE_BIT  1
`define CMS_CMD_PSEL_BIT   2
`define CMS_CMD_AINC_BIT   3

// status fields
`define CMS_ST_BUSY_BIT    0
`define CMS_ST_REFUSE_BIT  1
`define CMS_ST_PEND_BIT    2
`define CMS_ST_RDATA_LSB   8

// port configuration
`define CMS_PC_EXT_BIT     0
`define CMS_PC_RESET       1'b1

// timing counts in system clocks, except CMS_MD_OFFSET in instruction cycles
`define CMS_CLK_PER_ICYC   3'h4
`define CMS_TMR_SLOW       4'hc
`define CMS_TMR_FAST       4'h4
`define CMS_ALE_CLKS       5'h02
`define CMS_HOLD_CLKS      5'h01
`define CMS_STB_MIN        5'h02
`define CMS_MD_OFFSET      3'h2

`endif

// [hdl/cms_sync.v]
`timescale 1ns/10ps
module cms_sync
#(
  parameter W = 16
)
(
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second
  always @(posedge clock)
  begin
    if (rst)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// [hdl/cms_top.v]
// Behaviour
// - one instruction cycle lasts 4 system clocks, not 12.
// - the system clock is the oscillator itself, with no division inside.
// - the timer steps every 12 clocks by default, every 4 when the fast option is set.
// - an external data move takes the stretch field value plus two instruction cycles.
// - the read or write strobe lasts 2 clocks for code 0, else four times the code; default code is 1.
// - the 16-bit address goes out high byte on the second port, low byte on the first port.
// - the low address byte shares the first port with data and must be latched outside first.
// - a configuration bit selects external bus or general-purpose I/O for both ports.
// - two independent data pointers serve external data moves.
// - each operation gives the same results as the standard core; only timing differs.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "cms_consts.vh"
module cms_top
(
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [7:0]  first_port_i,
  output wire [7:0]  first_port_o,
  output wire [7:0]  first_port_oe,
  input  wire [7:0]  second_port_i,
  output wire [7:0]  second_port_o,
  output wire [7:0]  second_port_oe,
  output wire        addr_latch,
  output wire        rd_strobe_n,
  output wire        wr_strobe_n
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_HOLD = 5'b00100;
  localparam [4:0] ST_STB  = 5'b01000;
  localparam [4:0] ST_TAIL = 5'b10000;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0]  stretch_ctl_ff;
  reg [15:0] dp0_ff;
  reg [15:0] dp1_ff;
  reg [3:0]  cmd_ff;
  reg [7:0]  wdata_ff;
  reg        pend_ff;
  reg        refuse_ff;
  reg [7:0]  rdata_ff;
  reg        ext_mode_ff;
  reg [15:0] gpio_out_ff;
  reg [15:0] gpio_oe_ff;
  reg [1:0]  phase_ff;
  reg [15:0] icyc_ff;
  reg [3:0]  pre_ff;
  reg [15:0] timer_ff;
  reg [4:0]  state_ff;
  reg [4:0]  cnt_ff;
  reg [2:0]  md_lat_ff;
  reg [15:0] addr_ff;
  reg [31:0] readdata_ff;
  reg        wait_ff;
  reg        ale_ff;
  reg        rd_n_ff;
  reg        wr_n_ff;
  reg [7:0]  fp_o_ff;
  reg [7:0]  fp_oe_ff;
  reg [7:0]  sp_o_ff;
  reg [7:0]  sp_oe_ff;

  wire [15:0] pin_sync;

  cms_sync #(.W(16)) u_sync
  (
    .clock (clock),
    .rst   (rst),
    .din   ({second_port_i, first_port_i}),
    .dout  (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one answer per request, one cycle after it is accepted

  wire req      = (avs_read | avs_write) & wait_ff;
  wire busy     = ~state_ff[0] | pend_ff;
  wire cmd_hit  = (avs_address == `CMS_IDX_CMD);
  // a new command waits while the previous access is still running
  wire stall    = avs_write & cmd_hit & busy;
  wire acc      = req & ~stall;
  wire wr_acc   = acc & avs_write;
  wire [2:0] md = stretch_ctl_ff[`CMS_CK_MD_MSB:`CMS_CK_MD_LSB];

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (avs_address == `CMS_IDX_STRETCH)
      rd_mux = {24'h00_0000, 4'h0, stretch_ctl_ff[3:0]};
    else if (avs_address == `CMS_IDX_DP0)
      rd_mux = {16'h0000, dp0_ff};
    else if (avs_address == `CMS_IDX_DP1)
      rd_mux = {16'h0000, dp1_ff};
    else if (avs_address == `CMS_IDX_CMD)
      rd_mux = {28'h000_0000, cmd_ff};
    else if (avs_address == `CMS_IDX_WDATA)
      rd_mux = {24'h00_0000, wdata_ff};
    else if (avs_address == `CMS_IDX_STATUS)
      rd_mux = {16'h0000, rdata_ff, 5'h00, pend_ff, refuse_ff, busy};
    else if (avs_address == `CMS_IDX_PORTCFG)
      rd_mux = {31'h0000_0000, ext_mode_ff};
    else if (avs_address == `CMS_IDX_GPIO_OUT)
      rd_mux = {16'h0000, gpio_out_ff};
    else if (avs_address == `CMS_IDX_GPIO_OE)
      rd_mux = {16'h0000, gpio_oe_ff};
    else if (avs_address == `CMS_IDX_GPIO_IN)
      rd_mux = {16'h0000, pin_sync};
    else if (avs_address == `CMS_IDX_TIMER)
      rd_mux = {16'h0000, timer_ff};
    else if (avs_address == `CMS_IDX_ICYCLES)
      rd_mux = {16'h0000, icyc_ff};
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      wait_ff     <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wait_ff <= ~acc;
      if (acc & avs_read)
        readdata_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle phase and timer prescale

  always @(posedge clock)
  begin
    if (rst)
    begin
      phase_ff <= 2'h0;
      icyc_ff  <= 16'h0000;
      pre_ff   <= 4'h0;
      timer_ff <= 16'h0000;
    end
    else
    begin
      // system clock used directly, no divider ahead of the phase count
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3)
        icyc_ff <= icyc_ff + 16'h0001;
      // a narrowed prescale limit restarts cleanly since the compare is >=
      if ({1'b0, pre_ff} + 5'h01 >=
          {1'b0, stretch_ctl_ff[`CMS_CK_TFAST_BIT] ? `CMS_TMR_FAST : `CMS_TMR_SLOW})
      begin
        pre_ff   <= 4'h0;
        timer_ff <= timer_ff + 16'h0001;
      end
      else
        pre_ff <= pre_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  wire start_req = wr_acc & cmd_hit & avs_writedata[`CMS_CMD_START_BIT];
  wire launch    = state_ff[0] & pend_ff & (phase_ff == 2'h3);
  wire acc_done  = state_ff[4] & (cnt_ff == 5'h01);
  wire [15:0] sel_dp = cmd_ff[`CMS_CMD_PSEL_BIT] ? dp1_ff : dp0_ff;

  always @(posedge clock)
  begin
    if (rst)
    begin
      stretch_ctl_ff <= `CMS_CK_RESET;
      dp0_ff      <= 16'h0000;
      dp1_ff      <= 16'h0000;
      cmd_ff      <= 4'h0;
      wdata_ff    <= 8'h00;
      pend_ff     <= 1'b0;
      refuse_ff   <= 1'b0;
      ext_mode_ff <= `CMS_PC_RESET;
      gpio_out_ff <= 16'h0000;
      gpio_oe_ff  <= 16'h0000;
    end
    else
    begin
      if (wr_acc & (avs_address == `CMS_IDX_STRETCH))
        stretch_ctl_ff <= {4'h0, avs_writedata[3:0]};
      if (wr_acc & (avs_address == `CMS_IDX_WDATA))
        wdata_ff <= avs_writedata[7:0];
      if (wr_acc & (avs_address == `CMS_IDX_PORTCFG))
        ext_mode_ff <= avs_writedata[`CMS_PC_EXT_BIT];
      if (wr_acc & (avs_address == `CMS_IDX_GPIO_OUT))
        gpio_out_ff <= avs_writedata[15:0];
      if (wr_acc & (avs_address == `CMS_IDX_GPIO_OE))
        gpio_oe_ff <= avs_writedata[15:0];
      if (wr_acc & cmd_hit)
        cmd_ff <= avs_writedata[3:0];
      // a started move in port I/O mode is refused; set wins over clear
      if (start_req & ~ext_mode_ff)
        refuse_ff <= 1'b1;
      else if (wr_acc & (avs_address == `CMS_IDX_STATUS) & avs_writedata[`CMS_ST_REFUSE_BIT])
        refuse_ff <= 1'b0;
      if (start_req & ext_mode_ff)
        pend_ff <= 1'b1;
      else if (launch)
        pend_ff <= 1'b0;
      // pointers are independent; increment wraps at 16 bits as on the standard core
      if (acc_done & cmd_ff[`CMS_CMD_AINC_BIT] & ~cmd_ff[`CMS_CMD_PSEL_BIT])
        dp0_ff <= dp0_ff + 16'h0001;
      else if (wr_acc & (avs_address == `CMS_IDX_DP0))
        dp0_ff <= avs_writedata[15:0];
      if (acc_done & cmd_ff[`CMS_CMD_AINC_BIT] & cmd_ff[`CMS_CMD_PSEL_BIT])
        dp1_ff <= dp1_ff + 16'h0001;
      else if (wr_acc & (avs_address == `CMS_IDX_DP1))
        dp1_ff <= avs_writedata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external access sequencer
  // total = 4*(md+2) clocks: address 2, hold 1, strobe, tail for the rest

  wire [4:0] stb_len = (md_lat_ff == 3'h0) ? `CMS_STB_MIN : {md_lat_ff, 2'b00};
  wire [5:0] tot_len = {({1'b0, md_lat_ff} + {1'b0, `CMS_MD_OFFSET}), 2'b00};
  wire [5:0] fixed   = {1'b0, `CMS_ALE_CLKS} + {1'b0, `CMS_HOLD_CLKS} + {1'b0, stb_len};
  wire [5:0] tail_w  = tot_len - fixed;

  reg [4:0] nxt_state;
  reg [4:0] nxt_cnt;

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        // moves start on an instruction cycle boundary
        if (launch)
        begin
          nxt_state = ST_ADDR;
          nxt_cnt   = `CMS_ALE_CLKS;
        end
      end
      ST_ADDR:
      begin
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == 5'h01)
        begin
          nxt_state = ST_HOLD;
          nxt_cnt   = `CMS_HOLD_CLKS;
        end
      end
      ST_HOLD:
      begin
        nxt_state = ST_STB;
        nxt_cnt   = stb_len;
      end
      ST_STB:
      begin
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == 5'h01)
        begin
          nxt_state = ST_TAIL;
          nxt_cnt   = tail_w[4:0];
        end
      end
      ST_TAIL:
      begin
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == 5'h01)
          nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 5'h00;
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 5'h00;
      md_lat_ff <= 3'h1;
      addr_ff   <= 16'h0000;
      rdata_ff  <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (launch)
      begin
        md_lat_ff <= md;
        addr_ff   <= sel_dp;
      end
      // the synchroniser lags two clocks, so this picks the pin value of the last strobe clock
      if (state_ff[4] & (cnt_ff == tail_w[4:0] - 5'h01) & ~cmd_ff[`CMS_CMD_WRITE_BIT])
        rdata_ff <= pin_sync[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, all registered

  reg        nxt_ale;
  reg        nxt_rd_n;
  reg        nxt_wr_n;
  reg [7:0]  nxt_fp_o;
  reg [7:0]  nxt_fp_oe;
  reg [7:0]  nxt_sp_o;
  reg [7:0]  nxt_sp_oe;

  always @*
  begin
    nxt_ale   = 1'b0;
    nxt_rd_n  = 1'b1;
    nxt_wr_n  = 1'b1;
    nxt_fp_o  = 8'h00;
    nxt_fp_oe = 8'h00;
    nxt_sp_o  = addr_ff[15:8];
    nxt_sp_oe = 8'hff;
    if (~ext_mode_ff)
    begin
      nxt_fp_o  = gpio_out_ff[7:0];
      nxt_fp_oe = gpio_oe_ff[7:0];
      nxt_sp_o  = gpio_out_ff[15:8];
      nxt_sp_oe = gpio_oe_ff[15:8];
    end
    else if (nxt_state[1] | nxt_state[2])
    begin
      nxt_ale   = nxt_state[1];
      nxt_fp_o  = launch ? sel_dp[7:0] : addr_ff[7:0];
      nxt_fp_oe = 8'hff;
      nxt_sp_o  = launch ? sel_dp[15:8] : addr_ff[15:8];
    end
    else if (nxt_state[3])
    begin
      // strobe only after the latch pulse has ended and the address held
      nxt_rd_n  = cmd_ff[`CMS_CMD_WRITE_BIT];
      nxt_wr_n  = ~cmd_ff[`CMS_CMD_WRITE_BIT];
      nxt_fp_o  = wdata_ff;
      nxt_fp_oe = {8{cmd_ff[`CMS_CMD_WRITE_BIT]}};
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      ale_ff   <= 1'b0;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      fp_o_ff  <= 8'h00;
      fp_oe_ff <= 8'h00;
      sp_o_ff  <= 8'h00;
      sp_oe_ff <= 8'h00;
    end
    else
    begin
      ale_ff   <= nxt_ale;
      rd_n_ff  <= nxt_rd_n;
      wr_n_ff  <= nxt_wr_n;
      fp_o_ff  <= nxt_fp_o;
      fp_oe_ff <= nxt_fp_oe;
      sp_o_ff  <= nxt_sp_o;
      sp_oe_ff <= nxt_sp_oe;
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign first_port_o    = fp_o_ff;
  assign first_port_oe   = fp_oe_ff;
  assign second_port_o   = sp_o_ff;
  assign second_port_oe  = sp_oe_ff;
  assign addr_latch      = ale_ff;
  assign rd_strobe_n     = rd_n_ff;
  assign wr_strobe_n     = wr_n_ff;

endmodule

// [verification/cms_top_asserts.sv]
`timescale 1ns/10ps
`include "cms_consts.vh"
module cms_top_asserts
(
  input wire        clock,
  input wire        rst,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [7:0]  first_port_i,
  input wire [7:0]  first_port_o,
  input wire [7:0]  first_port_oe,
  input wire [7:0]  second_port_i,
  input wire [7:0]  second_port_o,
  input wire [7:0]  second_port_oe,
  input wire        addr_latch,
  input wire        rd_strobe_n,
  input wire        wr_strobe_n
);
  reg  [2:0] md_ff;
  reg  [4:0] cnt_ff;
  reg  [5:0] gap_ff;
  reg  [5:0] len_ff;
  reg        ale_q;
  wire       stb_on;
  wire [4:0] width;
  assign stb_on = !rd_strobe_n || !wr_strobe_n;
  assign width  = (md_ff == 3'h0) ? 5'h02 : {md_ff, 2'h0};
  ////////////////////////////////////////////////////////////
  // stretch code mirrored from bus writes, so no internals are needed
  always @(posedge clock)
  begin
    if (rst)
      md_ff <= 3'h1;
    else if (avs_write && !avs_waitrequest && avs_address == `CMS_IDX_STRETCH)
      md_ff <= avs_writedata[2:0];
    cnt_ff <= (rst || !stb_on) ? 5'h00 : cnt_ff + 5'h01;
    gap_ff <= (rst || (addr_latch && gap_ff != 6'h00)) ? 6'h3f : gap_ff;
    ale_q  <= addr_latch;
    if (!rst && addr_latch && !ale_q)
      gap_ff <= 6'h01;
    else if (!rst && gap_ff != 6'h3f)
      gap_ff <= gap_ff + 6'h01;
    if (!rst && addr_latch && !ale_q)
      len_ff <= {md_ff + 4'h2, 2'h0};
    else if (rst)
      len_ff <= 6'h00;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_latch_len: assert property ($rose(addr_latch) |=> addr_latch ##1 !addr_latch)
    else $error("address latch pulse is not two clocks");
  a_latch_first: assert property ($fell(rd_strobe_n && wr_strobe_n) |-> !$past(addr_latch) && $past(addr_latch, 2))
    else $error("strobe not preceded by address latch");
  a_latch_quiet: assert property (addr_latch |-> rd_strobe_n && wr_strobe_n)
    else $error("strobe during address latch");
  a_addr_drive: assert property (addr_latch |-> first_port_oe == 8'hff && second_port_oe == 8'hff)
    else $error("address not driven on both ports");
  a_addr_held: assert property ($fell(addr_latch) |-> $stable(first_port_o) && first_port_oe == 8'hff)
    else $error("low address not held after latch");
  a_read_free: assert property (!rd_strobe_n |-> first_port_oe == 8'h00)
    else $error("first port driven during read");
  a_write_drive: assert property (!wr_strobe_n |-> first_port_oe == 8'hff)
    else $error("write data not driven");
  a_strobe_width: assert property ($rose(rd_strobe_n && wr_strobe_n) |-> cnt_ff == width)
    else $error("strobe width wrong");
  a_access_min: assert property ($rose(addr_latch) && len_ff != 6'h00 |-> gap_ff >= len_ff)
    else $error("access shorter than stretch allows");
  c_read: cover property ($rose(rd_strobe_n) && md_ff == 3'h7);
  c_write: cover property ($rose(wr_strobe_n) && md_ff == 3'h0);
  c_gap: cover property ($rose(addr_latch) && gap_ff == len_ff);
endmodule
bind cms_top cms_top_asserts u_chk
(
  .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .first_port_i(first_port_i), .first_port_o(first_port_o), .first_port_oe(first_port_oe),
  .second_port_i(second_port_i), .second_port_o(second_port_o), .second_port_oe(second_port_oe),
  .addr_latch(addr_latch), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n)
);

// [verification/cms_mem_model.sv]
`timescale 1ns/10ps
module cms_mem_model
(
  input  wire       clock,
  input  wire [1:0] lag,
  input  wire [7:0] first_port_o,
  input  wire [7:0] second_port_o,
  input  wire       addr_latch,
  input  wire       rd_strobe_n,
  input  wire       wr_strobe_n,
  output wire [7:0] first_port_i
);
  reg [7:0]  mem [0:65535];
  integer    n;
  reg [15:0] adr_ff;
  reg [4:0]  age_ff;
  reg [7:0]  junk_ff;
  wire [7:0] val;
  assign val = mem[adr_ff];
  // no pull-up on the port: outside a read the lines toggle, never hold
  assign first_port_i = (!rd_strobe_n && age_ff >= {3'h0, lag}) ? val : junk_ff;
  // unwritten locations read back as high byte xor low byte of their address
  initial
  begin
    junk_ff = 8'h00;
    for (n = 0; n < 65536; n = n + 1)
      mem[n] = n[15:8] ^ n[7:0];
  end
  always @(posedge clock)
  begin
    if (addr_latch)
      adr_ff <= {second_port_o, first_port_o};
    if (!wr_strobe_n)
      mem[adr_ff] <= first_port_o;
    age_ff <= rd_strobe_n ? 5'h00 : age_ff + 5'h01;
    junk_ff <= ~first_port_i;
  end
endmodule

// [verification/cms_top_tb.sv]
`timescale 1ns/10ps
`include "cms_consts.vh"
module cms_top_tb;
  reg         clock;
  reg         rst;
  reg  [7:0]  avs_address;
  reg         avs_read;
  reg         avs_write;
  reg  [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [7:0]  mem_dq;
  reg  [7:0]  second_port_i;
  wire [7:0]  first_port_o;
  wire [7:0]  first_port_oe;
  wire [7:0]  second_port_o;
  wire [7:0]  second_port_oe;
  wire        addr_latch;
  wire        rd_strobe_n;
  wire        wr_strobe_n;
  reg  [1:0]  lag;
  reg  [31:0] stb_cnt;
  reg  [31:0] gap_c;
  reg  [31:0] last_gap;
  reg         lat_q;
  integer     errors;
  integer     tests_run;
  integer     k;
  cms_top DUT
  (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_port_i(mem_dq), .first_port_o(first_port_o), .first_port_oe(first_port_oe),
    .second_port_i(second_port_i), .second_port_o(second_port_o), .second_port_oe(second_port_oe),
    .addr_latch(addr_latch), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n)
  );
  cms_mem_model u_mem
  (
    .clock(clock), .lag(lag), .first_port_o(first_port_o), .second_port_o(second_port_o),
    .addr_latch(addr_latch), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .first_port_i(mem_dq)
  );
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    stb_cnt <= stb_cnt + {31'h0, !rd_strobe_n || !wr_strobe_n};
    gap_c <= (addr_latch && !lat_q) ? 32'h1 : gap_c + 32'h1;
    if (addr_latch && !lat_q)
      last_gap <= gap_c;
    lat_q <= addr_latch;
  end
  ////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // one edge passes first, so back-to-back calls never drive twice in a step
  task bus(input [7:0] a, input w, input [31:0] d, output [31:0] q);
    integer i;
  begin
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    i = 0;
    @(posedge clock);
    // waits as long as the slave needs; only the watchdog ends a hang
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clock);
      i = i + 1;
    end
    // only a stalled command write may wait longer than one cycle
    chk({31'h0, i != 1 && a != `CMS_IDX_CMD}, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
  begin
    bus(a, 1'b1, d, q);
  end
  endtask
  task idle(output [31:0] q);
  begin
    bus(`CMS_IDX_STATUS, 1'b0, 32'h0, q);
    while (q[0] !== 1'b0 || q[2] !== 1'b0)
      bus(`CMS_IDX_STATUS, 1'b0, 32'h0, q);
  end
  endtask
  task conclude;
  begin
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  task t_defaults;
    reg [31:0] q;
  begin
    bus(`CMS_IDX_STRETCH, 1'b0, 32'h0, q);
    chk({24'h0, q[7:0]}, 32'h1);
    bus(`CMS_IDX_PORTCFG, 1'b0, 32'h0, q);
    chk({31'h0, q[0]}, 32'h1);
    bus(8'h10, 1'b0, 32'h0, q);
    chk(q, 32'h0);
  end
  endtask
  // reads 48 clocks apart, a whole multiple of both timer rates
  task t_rate(input f);
    reg [31:0] t0, i0, t1, i1;
  begin
    wr(`CMS_IDX_STRETCH, {28'h0, f, 3'h1});
    bus(`CMS_IDX_TIMER, 1'b0, 32'h0, t0);
    bus(`CMS_IDX_ICYCLES, 1'b0, 32'h0, i0);
    repeat (42) @(posedge clock);
    bus(`CMS_IDX_TIMER, 1'b0, 32'h0, t1);
    bus(`CMS_IDX_ICYCLES, 1'b0, 32'h0, i1);
    chk((t1 - t0) & 32'hffff, f ? 32'hc : 32'h4);
    chk((i1 - i0) & 32'hffff, 32'hc);
  end
  endtask
  task t_move(input [2:0] md);
    reg [31:0] q, s;
  begin
    lag <= (md > 3'h1) ? 2'h2 : 2'h0;
    wr(`CMS_IDX_STRETCH, {29'h0, md});
    wr(`CMS_IDX_DP0, {16'h0, 8'h12, 5'h0, md});
    wr(`CMS_IDX_DP1, {16'h0, 8'h12, 5'h0, md});
    wr(`CMS_IDX_WDATA, {24'h0, 8'hc3 ^ {5'h0, md}});
    s = stb_cnt;
    wr(`CMS_IDX_CMD, 32'hb);
    idle(q);
    chk(stb_cnt - s, (md == 3'h0) ? 32'h2 : {27'h0, md, 2'h0});
    bus(`CMS_IDX_DP0, 1'b0, 32'h0, q);
    chk(q & 32'hffff, {16'h0, 8'h12, 5'h0, md} + 32'h1);
    wr(`CMS_IDX_CMD, 32'h5);
    idle(q);
    chk({24'h0, q[15:8]}, {24'h0, 8'hc3 ^ {5'h0, md}});
    wr(`CMS_IDX_DP1, {16'h0, 8'h5a, 5'h0, md});
    wr(`CMS_IDX_CMD, 32'h5);
    idle(q);
    chk({24'h0, q[15:8]}, {24'h0, 8'h5a ^ {5'h0, md}});
  end
  endtask
  task t_gap(input [2:0] md);
    reg [31:0] q, n;
  begin
    n = {27'h0, md, 2'h0} + 32'h8;
    wr(`CMS_IDX_STRETCH, {29'h0, md});
    wr(`CMS_IDX_CMD, 32'h1);
    wr(`CMS_IDX_CMD, 32'h1);
    idle(q);
    chk({31'h0, last_gap >= n && last_gap <= n + 32'h4 && last_gap[1:0] == 2'h0}, 32'h1);
  end
  endtask
  // pins are looked at one edge after the write, once their registers have settled
  task t_gpio;
    reg [31:0] q;
  begin
    wr(`CMS_IDX_PORTCFG, 32'h0000_0000);
    wr(`CMS_IDX_GPIO_OUT, 32'h0000_5a3c);
    wr(`CMS_IDX_GPIO_OE, 32'h0000_f00f);
    @(posedge clock);
    chk({second_port_o, first_port_o, second_port_oe, first_port_oe}, 32'h5a3c_f00f);
    bus(`CMS_IDX_GPIO_IN, 1'b0, 32'h0000_0000, q);
    chk({24'h00_0000, q[15:8]}, 32'h0000_00a5);
    wr(`CMS_IDX_PORTCFG, 32'h0000_0001);
  end
  endtask
  task t_refuse;
    reg [31:0] q, s;
  begin
    wr(`CMS_IDX_PORTCFG, 32'h0);
    s = stb_cnt;
    wr(`CMS_IDX_CMD, 32'h1);
    bus(`CMS_IDX_STATUS, 1'b0, 32'h0, q);
    chk(q & 32'h7, 32'h2);
    wr(`CMS_IDX_STATUS, 32'h2);
    bus(`CMS_IDX_STATUS, 1'b0, 32'h0, q);
    chk(q & 32'h7, 32'h0);
    chk(stb_cnt - s, 32'h0);
    wr(`CMS_IDX_PORTCFG, 32'h1);
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    second_port_i = 8'ha5;
    lag = 2'h0;
    stb_cnt = 32'h0;
    gap_c = 32'h0;
    last_gap = 32'h0;
    lat_q = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_defaults;
    t_rate(1'b0);
    t_rate(1'b1);
    for (k = 0; k < 8; k = k + 1)
      t_move(k[2:0]);
    t_gap(3'h0);
    t_gap(3'h3);
    t_gpio;
    t_refuse;
    conclude;
  end
  initial
  begin
    repeat (30000) @(posedge clock);
    errors = errors + 1;
    conclude;
  end
endmodule
